// ### rtl/tpw_pkg.sv
package tpw_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_MODE_REG = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h08;
  localparam logic [7:0] ADDR_GPRESC   = 8'h0c;
  localparam logic [7:0] ADDR_TMR_BASE = 8'h10;
  localparam logic [7:0] TMR_STRIDE    = 8'h10;
  localparam logic [7:0] OFS_TL        = 8'h00;
  localparam logic [7:0] OFS_TH        = 8'h04;
  localparam logic [7:0] OFS_RL        = 8'h08;
  localparam logic [7:0] OFS_RH        = 8'h0c;

  // Reset values.
  localparam logic [7:0] MODE_REG_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST   = 8'h24;
  localparam logic [3:0] GPRESC_RST   = 4'h0;

  // Byte constants.
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;
  localparam logic [7:0] BYTE_MAX  = 8'hff;

  // Field positions in timer_mode_register (per timer span of four bits).
  localparam int TM_MODE_LSB = 0;
  localparam int TM_CT       = 2;
  localparam int TM_GATE     = 3;
  localparam int TM_SPAN     = 4;

  // Field positions in the timer control register.
  localparam int TC_RUN0  = 0;
  localparam int TC_RUN1  = 1;
  localparam int TC_FLAG0 = 2;
  localparam int TC_FLAG1 = 3;

  // Field positions in timer_control_b.
  localparam int TB_PWM0 = 6;
  localparam int TB_PWM1 = 7;
  localparam int PSC_W   = 3;
  localparam logic [2:0] PSC_MAX = 3'h7;

  localparam int GPRESC_W = 4;

  typedef enum logic [1:0] {
    TPW_MODE0 = 2'b00,
    TPW_MODE1 = 2'b01,
    TPW_MODE2 = 2'b10,
    TPW_MODE3 = 2'b11
  } tpw_mode_t;

endpackage

// ### rtl/tpw_cmp.sv
`timescale 1ns/1ps
module tpw_cmp (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       step,
  input  wire logic [7:0] cnt_nxt,
  input  wire logic [7:0] duty,
  output logic            level
);

  logic [7:0] cmp_r;
  logic [7:0] cmp_nxt;
  logic       lvl_r;
  logic       lvl_nxt;
  wire        wrap;
  wire        hit;

  // The duty value is only sampled at the wrap so a write mid-period never glitches.
  assign wrap    = step & (cnt_nxt == tpw_pkg::BYTE_ZERO);
  assign hit     = step & (cnt_nxt == cmp_r);
  assign cmp_nxt = wrap ? duty : cmp_r;
  // A zero duty leaves the output low through the whole period.
  assign lvl_nxt = wrap ? (duty != tpw_pkg::BYTE_ZERO) : (hit ? 1'b0 : lvl_r);

  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_r <= tpw_pkg::BYTE_ZERO;
      lvl_r <= 1'b0;
    end else begin
      cmp_r <= cmp_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;

endmodule

// ### rtl/tpw_timers.sv
// Functional notes
// - Timers 0 and 1 each become an independent 8-bit PWM when enabled.
// - In PWM operation the waveform drives the timer's own external pin.
// - Overflow flags keep working; timer 1 still feeds the UART baud rate.
// - Gate input still halts counting, and with it the waveform, except timer 1 and the split high channel while timer 0 is split.
// - At high byte wrap load duty and go high; go low on compare match.
// - Duty writes take effect only at the FFH to 00H wrap.
// - Duty value 00H keeps the output low for the whole period.
// - Mode 0 uses low byte as log prescaler, period 256 times 2^(field+1).
// - Mode 1 reloads low byte from reload value; high advances per 256-reload.
// - Mode 2 is 8-bit auto-reload; pin toggles on each low byte overflow.
// - Mode 2 leaves both duty/reload holding registers unused by hardware.
// - Timer 1 in mode 3 holds its count, like run cleared.
// - Timer 0 mode 3 runs low and high bytes as two 256-step PWM counters.
// - Split low channel uses timer 0 controls; high uses timer 1 run/enable/flag.
// - Split mode duty: low reload for low channel, high reload for high channel.
// - With timer 0 split, timer 1 runs unless in mode 3, baud only.
// - Four modes per timer, chosen by the two timer mode bits; modes 0, 1 and split mode 3 give PWM.
// - Prescale field gives active low byte bits as field+1; resets to 100B.
// - Control register B holds enables in bits 7/6, prescale fields below.
`timescale 1ns/1ps
module tpw_timers (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_gate_input0,
  input  wire logic        external_gate_input1,
  input  wire logic        timer0_pin_i,
  output logic             timer0_pin_o,
  output logic             timer0_pin_oe,
  input  wire logic        timer1_pin_i,
  output logic             timer1_pin_o,
  output logic             timer1_pin_oe,
  output logic             timer0_overflow_flag,
  output logic             timer1_overflow_flag,
  output logic             timer1_baud_tick
);

  logic [7:0]                 timer_mode_register_r;
  logic [7:0]                 timer_control_b_r;
  logic [1:0]                 run_r;
  logic [1:0]                 flag_r;
  logic [1:0]                 flag_nxt;
  logic [tpw_pkg::GPRESC_W-1:0] gpresc_r;
  logic [tpw_pkg::GPRESC_W-1:0] gpresc_cnt_r;
  logic [tpw_pkg::GPRESC_W-1:0] gpresc_cnt_nxt;
  logic [31:0]                prdata_r;
  logic                       pin0_r;
  logic                       pin1_r;
  logic                       baud_r;

  wire                        acc;
  wire                        wr_en;
  wire                        rd_setup;
  wire                        sel_mode;
  wire                        sel_ctrl;
  wire                        sel_ctrl_b;
  wire                        sel_gpresc;
  wire                        hit;
  wire  [7:0]                 tcon_rd;
  wire  [7:0]                 rd_byte;
  wire                        tick;
  wire                        split_mode0;
  wire  [1:0]                 ext_gate;
  wire  [1:0]                 t_hit;
  wire  [7:0]                 t_rd [2];
  wire  [1:0]                 ovf_ev;
  wire  [1:0]                 th_ovf_ev;
  wire  [1:0]                 th_step_ev;
  wire  [7:0]                 th_nxt_q [2];
  wire  [7:0]                 rh_q [2];
  wire  [1:0]                 pwm_lvl;
  wire                        split_hi_lvl;
  wire                        flag1_set;

  // APB slave: zero wait states, error on an address that maps nothing.
  assign acc       = psel & penable;
  assign wr_en     = acc & pwrite & pstrb[0];
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign sel_mode   = (paddr == tpw_pkg::ADDR_MODE_REG);
  assign sel_ctrl   = (paddr == tpw_pkg::ADDR_CTRL);
  assign sel_ctrl_b = (paddr == tpw_pkg::ADDR_CTRL_B);
  assign sel_gpresc = (paddr == tpw_pkg::ADDR_GPRESC);
  assign hit        = sel_mode | sel_ctrl | sel_ctrl_b | sel_gpresc | (|t_hit);
  assign pready    = 1'b1;
  assign pslverr   = acc & ~hit;
  assign prdata    = prdata_r;

  assign tcon_rd = {2'b00, timer1_pin_i, timer0_pin_i, flag_r, run_r};
  assign rd_byte = (sel_mode   ? timer_mode_register_r : tpw_pkg::BYTE_ZERO)
                 | (sel_ctrl   ? tcon_rd : tpw_pkg::BYTE_ZERO)
                 | (sel_ctrl_b ? timer_control_b_r : tpw_pkg::BYTE_ZERO)
                 | (sel_gpresc ? 8'(gpresc_r) : tpw_pkg::BYTE_ZERO)
                 | t_rd[0] | t_rd[1];

  // Global prescaler: one counting tick every setting+1 clocks.
  assign tick           = (gpresc_cnt_r == gpresc_r);
  assign gpresc_cnt_nxt = tick ? '0 : gpresc_cnt_r + 4'h1;

  assign split_mode0 = (tpw_pkg::tpw_mode_t'(timer_mode_register_r[1:0]) == tpw_pkg::TPW_MODE3);
  assign ext_gate = {external_gate_input1, external_gate_input0};

  // While timer 0 is split, the timer 1 flag belongs to the high byte channel.
  assign flag1_set = split_mode0 ? th_ovf_ev[0] : ovf_ev[1];

  // Hardware set wins over a software write-one-to-clear in the same cycle.
  assign flag_nxt[0] = ovf_ev[0]
                     | (flag_r[0] & ~(wr_en & sel_ctrl & pwdata[tpw_pkg::TC_FLAG0]));
  assign flag_nxt[1] = flag1_set
                     | (flag_r[1] & ~(wr_en & sel_ctrl & pwdata[tpw_pkg::TC_FLAG1]));

  always_ff @(posedge mclk) begin
    if (srst) begin
      timer_mode_register_r <= tpw_pkg::MODE_REG_RST;
      timer_control_b_r     <= tpw_pkg::CTRL_B_RST;
      run_r                 <= 2'b00;
      gpresc_r              <= tpw_pkg::GPRESC_RST;
    end else if (wr_en) begin
      if (sel_mode) begin
        timer_mode_register_r <= pwdata[7:0];
      end
      if (sel_ctrl_b) begin
        timer_control_b_r <= pwdata[7:0];
      end
      if (sel_ctrl) begin
        run_r <= {pwdata[tpw_pkg::TC_RUN1], pwdata[tpw_pkg::TC_RUN0]};
      end
      if (sel_gpresc) begin
        gpresc_r <= pwdata[tpw_pkg::GPRESC_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_r    <= 2'b00;
      gpresc_cnt_r <= '0;
      prdata_r  <= '0;
      pin0_r    <= 1'b0;
      pin1_r    <= 1'b0;
      baud_r    <= 1'b0;
    end else begin
      flag_r    <= flag_nxt;
      gpresc_cnt_r <= gpresc_cnt_nxt;
      if (rd_setup) begin
        prdata_r <= 32'(rd_byte);
      end
      pin0_r <= pwm_lvl[0];
      pin1_r <= split_mode0 ? split_hi_lvl : pwm_lvl[1];
      baud_r <= ovf_ev[1];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      localparam logic [7:0] TBASE = tpw_pkg::ADDR_TMR_BASE + 8'(gi) * tpw_pkg::TMR_STRIDE;
      localparam bit         IS_T0 = (gi == 0);

      logic [7:0]         tl_r;
      logic [7:0]         th_r;
      logic [7:0]         rl_r;
      logic [7:0]         rh_r;
      logic [7:0]         tl_nxt;
      logic [7:0]         th_nxt;
      logic               tog_r;
      wire  tpw_pkg::tpw_mode_t mode;
      wire                gate;
      wire  [2:0]         psc;
      wire                gated;
      wire                run;
      wire                split;
      wire  [7:0]         mask;
      wire  [7:0]         tl_inc;
      wire                tl_step;
      wire                tl_ovf;
      wire                th_step;
      wire                th_ovf;
      wire                s_tl;
      wire                s_th;
      wire                s_rl;
      wire                s_rh;
      wire                ch_step;
      wire  [7:0]         ch_cnt;
      wire  [7:0]         ch_duty;
      wire                ch_lvl;

      assign s_tl = (paddr == TBASE + tpw_pkg::OFS_TL);
      assign s_th = (paddr == TBASE + tpw_pkg::OFS_TH);
      assign s_rl = (paddr == TBASE + tpw_pkg::OFS_RL);
      assign s_rh = (paddr == TBASE + tpw_pkg::OFS_RH);
      assign t_hit[gi] = s_tl | s_th | s_rl | s_rh;
      assign t_rd[gi]  = (s_tl ? tl_r : tpw_pkg::BYTE_ZERO) | (s_th ? th_r : tpw_pkg::BYTE_ZERO)
                       | (s_rl ? rl_r : tpw_pkg::BYTE_ZERO) | (s_rh ? rh_r : tpw_pkg::BYTE_ZERO);

      assign mode = tpw_pkg::tpw_mode_t'(
                    timer_mode_register_r[tpw_pkg::TM_MODE_LSB + gi*tpw_pkg::TM_SPAN +: 2]);
      assign gate = timer_mode_register_r[tpw_pkg::TM_GATE + gi*tpw_pkg::TM_SPAN];
      assign psc  = timer_control_b_r[gi*tpw_pkg::PSC_W +: tpw_pkg::PSC_W];
      // The counter-select bit is stored but not acted on: only clock counting is built.
      assign gated = run_r[gi] & (~gate | ext_gate[gi]);
      assign split = IS_T0 & split_mode0;
      if (IS_T0) begin : g_run0
        assign run = gated;
      end else begin : g_run1
        // Split timer 0 borrows the timer 1 run bit, so mode 3 is the only off switch.
        assign run = (mode != tpw_pkg::TPW_MODE3) & (split_mode0 | gated);
      end

      assign tl_step = run & tick;
      assign mask    = (mode == tpw_pkg::TPW_MODE0) ? (tpw_pkg::BYTE_MAX >> (tpw_pkg::PSC_MAX - psc))
                                                    : tpw_pkg::BYTE_MAX;
      assign tl_inc  = (tl_r + tpw_pkg::BYTE_ONE) & mask;
      assign tl_ovf  = tl_step & ((tl_r & mask) == mask);
      assign th_step = split ? (run_r[1] & tick)
                     : (((mode == tpw_pkg::TPW_MODE0) | (mode == tpw_pkg::TPW_MODE1)) & tl_ovf);
      assign th_ovf  = th_step & (th_r == tpw_pkg::BYTE_MAX);

      always_comb begin
        tl_nxt = tl_r;
        if (wr_en & s_tl) begin
          tl_nxt = pwdata[7:0];
        end else if (tl_ovf) begin
          unique case (mode)
            tpw_pkg::TPW_MODE1: tl_nxt = rl_r;
            tpw_pkg::TPW_MODE2: tl_nxt = th_r;
            tpw_pkg::TPW_MODE0: tl_nxt = tpw_pkg::BYTE_ZERO;
            tpw_pkg::TPW_MODE3: tl_nxt = tpw_pkg::BYTE_ZERO;
          endcase
        end else if (tl_step) begin
          tl_nxt = tl_inc;
        end
      end

      always_comb begin
        th_nxt = th_r;
        if (wr_en & s_th) begin
          th_nxt = pwdata[7:0];
        end else if (th_step) begin
          th_nxt = th_r + tpw_pkg::BYTE_ONE;
        end
      end

      always_ff @(posedge mclk) begin
        if (srst) begin
          tl_r  <= tpw_pkg::BYTE_ZERO;
          th_r  <= tpw_pkg::BYTE_ZERO;
          rl_r  <= tpw_pkg::BYTE_ZERO;
          rh_r  <= tpw_pkg::BYTE_ZERO;
          tog_r <= 1'b0;
        end else begin
          tl_r <= tl_nxt;
          th_r <= th_nxt;
          if (wr_en & s_rl) begin
            rl_r <= pwdata[7:0];
          end
          if (wr_en & s_rh) begin
            rh_r <= pwdata[7:0];
          end
          if ((mode == tpw_pkg::TPW_MODE2) & tl_ovf) begin
            tog_r <= ~tog_r;
          end
        end
      end

      // Mode 2 and split mode 3 flag on the low byte, the other modes on the high byte.
      assign ovf_ev[gi]     = ((mode == tpw_pkg::TPW_MODE2) | split) ? tl_ovf : th_ovf;
      assign th_ovf_ev[gi]  = th_ovf;
      assign th_step_ev[gi] = th_step;
      assign th_nxt_q[gi]   = th_nxt;
      assign rh_q[gi]       = rh_r;

      // In mode 2 the channel output is ignored, so both holding registers stay free.
      assign ch_step = split ? tl_step : th_step;
      assign ch_cnt  = split ? tl_nxt : th_nxt;
      assign ch_duty = split ? rl_r : rh_r;

      tpw_cmp u_cmp (
        .mclk    (mclk),
        .srst    (srst),
        .step    (ch_step),
        .cnt_nxt (ch_cnt),
        .duty    (ch_duty),
        .level   (ch_lvl)
      );

      assign pwm_lvl[gi] = (mode == tpw_pkg::TPW_MODE2) ? tog_r : ch_lvl;
    end
  endgenerate

  // High byte channel of split timer 0, with its duty from the high reload register.
  tpw_cmp u_cmp_hi (
    .mclk    (mclk),
    .srst    (srst),
    .step    (th_step_ev[0] & split_mode0),
    .cnt_nxt (th_nxt_q[0]),
    .duty    (rh_q[0]),
    .level   (split_hi_lvl)
  );

  // The pins are driven only while PWM is enabled; otherwise they stay inputs.
  assign timer0_pin_o  = pin0_r;
  assign timer0_pin_oe = timer_control_b_r[tpw_pkg::TB_PWM0];
  assign timer1_pin_o  = pin1_r;
  assign timer1_pin_oe = timer_control_b_r[tpw_pkg::TB_PWM1];

  assign timer0_overflow_flag = flag_r[0];
  assign timer1_overflow_flag = flag_r[1];
  assign timer1_baud_tick     = baud_r;

endmodule

// ### bench/tpw_checker.sv
`timescale 1ns/1ps
module tpw_checker (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        external_gate_input0,
  input wire logic        timer0_pin_o,
  input wire logic        timer0_pin_oe,
  input wire logic        timer1_pin_o,
  input wire logic        timer1_pin_oe,
  input wire logic        timer0_overflow_flag,
  input wire logic        timer1_overflow_flag
);
  logic [7:0] mode_r;
  logic [1:0] age_r;
  wire        wr_hit = psel && penable && pwrite && pstrb[0];
  wire        cb_hit = wr_hit && paddr == tpw_pkg::ADDR_CTRL_B;
  wire        tc_hit = wr_hit && paddr == tpw_pkg::ADDR_CTRL;
  wire        tm_hit = wr_hit && paddr == tpw_pkg::ADDR_MODE_REG;
  // A mode write may switch a pin between channel sources without an overflow, so the
  // overflow checks wait until the mode has been steady for a few cycles.
  always_ff @(posedge mclk) begin
    if (srst || tm_hit) begin
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
    if (srst) begin
      mode_r <= 8'h00;
    end else if (tm_hit) begin
      mode_r <= pwdata[7:0];
    end
  end
  sequence gate_off;
    (mode_r[tpw_pkg::TM_GATE] && !external_gate_input0) [*3];
  endsequence
  default clocking chk_cb @(posedge mclk); endclocking
  default disable iff (srst);
  rst_state_a: assert property (disable iff (1'b0) srst |=> !timer0_pin_oe
    && !timer1_pin_oe && !timer0_overflow_flag && !timer1_overflow_flag)
    else $error("outputs not cleared by reset");
  pwm0_en_a: assert property (cb_hit |=> timer0_pin_oe == $past(pwdata[6]))
    else $error("timer0 pin enable wrong");
  pwm1_en_a: assert property (cb_hit |=> timer1_pin_oe == $past(pwdata[7]))
    else $error("timer1 pin enable wrong");
  oe_hold_a: assert property (!cb_hit |=> $stable({timer0_pin_oe, timer1_pin_oe}))
    else $error("pin enable moved without write");
  flag0_clear_a: assert property ($fell(timer0_overflow_flag) |->
    $past(tc_hit && pwdata[tpw_pkg::TC_FLAG0])) else $error("timer0 flag lost");
  flag1_clear_a: assert property ($fell(timer1_overflow_flag) |->
    $past(tc_hit && pwdata[tpw_pkg::TC_FLAG1])) else $error("timer1 flag lost");
  rise0_ovf_a: assert property (age_r == 2'h3 && $rose(timer0_pin_o) |->
    $past(timer0_overflow_flag)) else $error("timer0 pin rose without overflow");
  rise1_ovf_a: assert property (age_r == 2'h3 && $rose(timer1_pin_o) |->
    $past(timer1_overflow_flag)) else $error("timer1 pin rose without overflow");
  gate_halt_a: assert property (gate_off |=> ##1 $stable(timer0_pin_o))
    else $error("gated timer0 pin moved");
endmodule
bind tpw_timers tpw_checker u_tpw_checker (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .external_gate_input0(external_gate_input0), .timer0_pin_o(timer0_pin_o),
  .timer0_pin_oe(timer0_pin_oe), .timer1_pin_o(timer1_pin_o), .timer1_pin_oe(timer1_pin_oe),
  .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag));

// ### bench/tpw_load.sv
`timescale 1ns/1ps
module tpw_load (
  input  wire logic mclk,
  input  wire logic drv,
  input  wire logic drv_oe,
  input  wire logic clr,
  output logic      lvl,
  output int        rises,
  output int        high
);
  logic last_r;
  // The load has a pull-up, so a released pin reads high instead of keeping its last drive.
  assign lvl = drv_oe ? drv : 1'b1;
  always_ff @(posedge mclk) begin
    last_r <= lvl;
    if (clr) begin
      rises <= 0;
      high  <= 0;
    end else begin
      rises <= rises + int'(lvl && !last_r);
      high  <= high + int'(lvl);
    end
  end
endmodule

// ### bench/timer01_pwm_modes_tb.sv
`timescale 1ns/1ps
module timer01_pwm_modes_tb;
  logic        mclk, srst, psel, penable, pwrite, ext0, ext1, clr, erv, baud;
  logic        pready, pslverr, p0_o, p0_oe, p1_o, p1_oe, p0_lvl, p1_lvl;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdv, seed;
  int          r0, h0, r1, h1, nbaud, n_mismatch, samples_checked;

  tpw_timers dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_gate_input0(ext0), .external_gate_input1(ext1),
    .timer0_pin_i(p0_lvl), .timer0_pin_o(p0_o), .timer0_pin_oe(p0_oe), .timer1_pin_i(p1_lvl),
    .timer1_pin_o(p1_o), .timer1_pin_oe(p1_oe), .timer0_overflow_flag(),
    .timer1_overflow_flag(), .timer1_baud_tick(baud));
  tpw_load u_load0 (.mclk(mclk), .drv(p0_o), .drv_oe(p0_oe), .clr(clr), .lvl(p0_lvl),
    .rises(r0), .high(h0));
  tpw_load u_load1 (.mclk(mclk), .drv(p1_o), .drv_oe(p1_oe), .clr(clr), .lvl(p1_lvl),
    .rises(r1), .high(h1));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Baud pulses counted over the same window as the load counters.
  always @(posedge mclk) begin
    nbaud <= clr ? 0 : nbaud + int'(baud);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Cycles of one output period, from the mode formulas.
  function automatic int per_of(int md, int psc, int gp, int rl, int th);
    case (md)
      0: return 256 * (2 ** (psc + 1)) * (gp + 1);
      1: return 256 * (256 - rl) * (gp + 1);
      2: return 2 * (256 - th) * (gp + 1);
      default: return 256 * (gp + 1);
    endcase
  endfunction

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= 4'h1;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge mclk);
  endtask

  task automatic run_case(input int tm, input logic [7:0] mreg, cb, gp, rl, rh, th,
                          input logic held);
    logic [7:0] base;
    logic [1:0] m;
    int         md, per, k0, k1;
    base = (tm == 1) ? 8'h20 : 8'h10;
    md = (tm == 1) ? int'(mreg[5:4]) : int'(mreg[1:0]);
    per = held ? 0 : per_of(md, (tm == 1) ? int'(cb[5:3]) : int'(cb[2:0]), int'(gp),
                             int'(rl), int'(th));
    apb(1'b1, tpw_pkg::ADDR_MODE_REG, mreg);
    apb(1'b1, tpw_pkg::ADDR_GPRESC, gp);
    apb(1'b1, tpw_pkg::ADDR_CTRL_B, cb);
    apb(1'b1, base + tpw_pkg::OFS_RL, rl);
    apb(1'b1, base + tpw_pkg::OFS_RH, rh);
    if (md == 2) apb(1'b1, base + tpw_pkg::OFS_TH, th);
    apb(1'b1, tpw_pkg::ADDR_CTRL, 8'h0f);
    // Two periods plus 1024 cycles let the new duty pass through the wrap before the load counters are cleared.
    repeat (2 * per + 1024) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (held ? 512 : 2 * per) @(posedge mclk);
    #1;
    k0 = (md == 2) ? per : per * int'((tm == 2) ? rl : rh) / 128;
    k1 = (md == 2) ? per : per * int'(rh) / 128;
    if (tm != 1) begin
      chk("rises0", r0, (k0 != 0) ? 2 : 0);
      // A halted pin keeps whatever level it had when counting stopped.
      chk("high0", h0, held ? 512 * int'(p0_lvl) : k0);
    end
    if (tm != 0) begin
      chk("rises1", r1, (k1 != 0) ? 2 : 0);
      if (!held) chk("high1", h1, k1);
      if (tm == 1) chk("baud", nbaud, held ? 0 : ((md == 2) ? 4 : 2));
    end
    m = {tm != 0, tm != 1};
    apb(1'b0, tpw_pkg::ADDR_CTRL, 8'h00);
    chk("flags", {30'h0, rdv[3:2] & m}, held ? 32'h0 : {30'h0, m});
    apb(1'b0, base + tpw_pkg::OFS_RL, 8'h00);
    chk("reload", rdv, {24'h0, rl});
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ext0 = 1'b1;
    ext1 = 1'b1;
    clr = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    seed = 32'h0001_2584;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, tpw_pkg::ADDR_CTRL_B, 8'h00);
    chk("ctrl_b_rst", rdv, 32'h24);
    apb(1'b0, tpw_pkg::ADDR_MODE_REG, 8'h00);
    chk("mode_reg_rst", rdv, 32'h0);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped", {31'h0, erv}, 32'h1);
    run_case(0, 8'h00, 8'h40, 8'h01, 8'h00, 8'h40, 8'h00, 1'b0);
    run_case(1, 8'h00, 8'h88, 8'h00, 8'h00, 8'h10, 8'h00, 1'b0);
    run_case(0, 8'h01, 8'h40, 8'h00, 8'hfc, 8'h80, 8'h00, 1'b0);
    run_case(0, 8'h01, 8'h40, 8'h00, 8'hff, 8'h00, 8'h00, 1'b0);
    run_case(0, 8'h02, 8'h40, 8'h00, 8'ha5, 8'h5a, 8'hfc, 1'b0);
    run_case(1, 8'h20, 8'h80, 8'h02, 8'h3c, 8'hc3, 8'hf0, 1'b0);
    run_case(1, 8'h30, 8'h80, 8'h00, 8'h00, 8'h40, 8'h00, 1'b1);
    run_case(2, 8'h03, 8'hc0, 8'h00, 8'h40, 8'hc0, 8'h00, 1'b0);
    ext0 <= 1'b0;
    run_case(0, 8'h09, 8'h40, 8'h00, 8'hfc, 8'h80, 8'h00, 1'b1);
    ext0 <= 1'b1;
    run_case(0, 8'h09, 8'h40, 8'h00, 8'hfc, 8'h80, 8'h00, 1'b0);
    for (int j = 0; j < 2; j++) begin
      seed = xs(seed);
      run_case(0, 8'h01, 8'h40, 8'h00, 8'hf8 | seed[7:0], seed[15:8], 8'h00, 1'b0);
    end
    complete_run();
  end
endmodule
